// ===== design/ars_pkg.sv
// Purpose: constants and types of the automatic restart sequencer
// Assumes: 40 MHz system clock, 1 ms time base
// Notes: register map is one aligned 32-bit word per register
package ars_pkg;
   // ----------------------------------------
   // clock and time base
   // ----------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
   localparam logic [16:0] SETTLE_MS = 17'd1000;
   localparam logic [16:0] MIN_GAP_MS = 17'd1000;
   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_ATTEMPTS = 5'h04;
   localparam logic [4:0] OFS_WAIT = 5'h08;
   localparam logic [4:0] OFS_SUPERV = 5'h0c;
   localparam logic [4:0] OFS_STATUS = 5'h10;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_FLY_BIT = 4;
   localparam int CTRL_CLR_BIT = 8;
   localparam int STAT_CNT_LSB = 8;
   localparam int STAT_FAIL_BIT = 16;
   localparam int STAT_PWR_BIT = 17;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [2:0] RST_MODE = 3'h0;
   localparam logic RST_FLY = 1'b0;
   localparam logic [7:0] RST_ATTEMPTS = 8'h03;
   localparam logic [15:0] RST_WAIT_MS = 16'h03e8;
   localparam logic [15:0] RST_SUPERV_MS = 16'h0000;
   // ----------------------------------------
   // restart modes
   // ----------------------------------------
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_ACK_ONLY = 3'h1;
   localparam logic [2:0] MODE_LINE = 3'h4;
   localparam logic [2:0] MODE_ANY = 3'h6;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ACK, ST_GUARD, ST_HOLD, ST_POWER, ST_SETTLE, ST_FAILED
   } ars_state_e;

   // synchronised fault and status pins
   typedef struct packed {
      logic fault;
      logic cause_gone;
      logic motor_line;
      logic infeed_line;
      logic infeed_in0;
      logic infeed_in1;
      logic supply24_fail;
      logic line_ok;
      logic run;
      logic mag_done;
      logic is_infeed;
   } ars_pins_s;

   typedef struct packed {
      logic [2:0] mode;
      logic fly;
      logic [7:0] attempts;
      logic [15:0] wait_ms;
      logic [15:0] superv_ms;
   } ars_cfg_s;
endpackage

// ===== design/ars_sequencer.sv
// Purpose: automatic restart sequencer for a drive or infeed
// Assumes: pins asynchronous to CLK; registers over Avalon-MM
// Notes: all timing on a 1 ms enable derived from CLK
`timescale 1ns/1ps
module ars_sequencer import ars_pkg::*; #(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic FAULT_ACTIVE,
   input wire logic FAULT_CAUSE_GONE,
   input wire logic MOTOR_LINE_FAILURE_FAULT,
   input wire logic INFEED_LINE_FAULT,
   input wire logic [1:0] INFEED_FAULT_INPUTS,
   input wire logic SUPPLY24_FAIL,
   input wire logic LINE_OK,
   input wire logic RUN_COMMAND,
   input wire logic MAGNETIZATION_DONE_FLAG,
   input wire logic IS_INFEED,
   output logic FAULT_ACK,
   output logic POWER_UP,
   output logic RESTART_FAILED_FAULT,
   output logic FLYING_RESTART_ENABLE
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      ars_pins_s sync1;
      ars_pins_s sync2;
      ars_cfg_s cfg;
      logic [15:0] pre;
      ars_state_e st;
      logic [7:0] cnt;
      logic [15:0] ivl;
      logic [15:0] sv;
      logic sv_on;
      logic armed;
      logic [16:0] gap;
      logic ack;
      logic pwr;
      logic failed;
      logic wreq;
      logic [31:0] rdata;
   } ars_state_s;

   localparam ars_state_s RESET_S = '{
      sync1: '0, sync2: '0,
      cfg: '{mode: RST_MODE, fly: RST_FLY, attempts: RST_ATTEMPTS,
             wait_ms: RST_WAIT_MS, superv_ms: RST_SUPERV_MS},
      pre: 16'h0000, st: ST_IDLE, cnt: RST_ATTEMPTS, ivl: 16'h0000,
      sv: 16'h0000, sv_on: 1'b0, armed: 1'b0, gap: 17'h00000,
      ack: 1'b0, pwr: 1'b0, failed: 1'b0, wreq: 1'b1, rdata: 32'h00000000
   };

   localparam logic [15:0] TICK_LAST = 16'(TICK_LEN - 1);

   ars_state_s s;
   ars_state_s n;
   ars_pins_s pin_in;
   ars_pins_s p;
   logic tick;
   logic mode_ok;
   logic trig;
   logic [16:0] gap_need;
   logic take;
   logic clr;
   logic sv_expire;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [16:0] dec_ms(input logic [16:0] v);
      return (v == 17'h00000) ? v : 17'(v - 17'h00001);
   endfunction

   assign pin_in = '{fault: FAULT_ACTIVE, cause_gone: FAULT_CAUSE_GONE,
                     motor_line: MOTOR_LINE_FAILURE_FAULT, infeed_line: INFEED_LINE_FAULT,
                     infeed_in0: INFEED_FAULT_INPUTS[0], infeed_in1: INFEED_FAULT_INPUTS[1],
                     supply24_fail: SUPPLY24_FAIL, line_ok: LINE_OK, run: RUN_COMMAND,
                     mag_done: MAGNETIZATION_DONE_FLAG, is_infeed: IS_INFEED};
   assign p = s.sync2;
   assign tick = (s.pre == TICK_LAST);
   assign take = (AVS_READ || AVS_WRITE) && !s.wreq;

   // ----------------------------------------
   // trigger decode
   // ----------------------------------------
   always_comb begin
      mode_ok = 1'b0;
      trig = 1'b0;
      case (s.cfg.mode)
         MODE_ACK_ONLY: begin
            mode_ok = 1'b1;
            trig = p.fault;
         end
         MODE_LINE: begin
            mode_ok = 1'b1;
            trig = p.fault && (p.motor_line || p.infeed_in1 || p.supply24_fail
                               || (p.is_infeed && p.infeed_line));
         end
         MODE_ANY: begin
            mode_ok = 1'b1;
            trig = p.fault || p.infeed_in0;
         end
         default: begin
            mode_ok = 1'b0;
            trig = 1'b0;
         end
      endcase
      gap_need = p.run ? 17'(s.cfg.wait_ms + MIN_GAP_MS) : MIN_GAP_MS;
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      n = s;
      n.sync1 = pin_in;
      n.sync2 = s.sync1;
      n.pre = tick ? 16'h0000 : 16'(s.pre + 16'h0001);
      n.ack = 1'b0;
      clr = 1'b0;
      sv_expire = 1'b0;

      // bus slave: one wait cycle, then the answer
      n.wreq = 1'b1;
      if ((AVS_READ || AVS_WRITE) && s.wreq) begin
         n.wreq = 1'b0;
         n.rdata = 32'h00000000;
         case (AVS_ADDRESS)
            OFS_CTRL: n.rdata = {27'h0, s.cfg.fly, 1'b0, s.cfg.mode};
            OFS_ATTEMPTS: n.rdata = {24'h0, s.cfg.attempts};
            OFS_WAIT: n.rdata = {16'h0, s.cfg.wait_ms};
            OFS_SUPERV: n.rdata = {16'h0, s.cfg.superv_ms};
            OFS_STATUS: n.rdata = {14'h0, s.pwr, s.failed, s.cnt, 5'h00, s.st};
            default: n.rdata = 32'h00000000;
         endcase
      end
      if (take && AVS_WRITE) begin
         case (AVS_ADDRESS)
            OFS_CTRL: begin
               n.cfg.mode = 3'(be_merge({29'h0, s.cfg.mode}, AVS_WRITEDATA, AVS_BYTEENABLE));
               if (AVS_BYTEENABLE[0]) begin
                  n.cfg.fly = AVS_WRITEDATA[CTRL_FLY_BIT];
               end
               clr = AVS_BYTEENABLE[1] && AVS_WRITEDATA[CTRL_CLR_BIT];
            end
            OFS_ATTEMPTS: begin
               n.cfg.attempts = 8'(be_merge({24'h0, s.cfg.attempts}, AVS_WRITEDATA, AVS_BYTEENABLE));
               n.cnt = n.cfg.attempts;
            end
            OFS_WAIT: n.cfg.wait_ms = 16'(be_merge({16'h0, s.cfg.wait_ms}, AVS_WRITEDATA, AVS_BYTEENABLE));
            OFS_SUPERV: n.cfg.superv_ms = 16'(be_merge({16'h0, s.cfg.superv_ms}, AVS_WRITEDATA, AVS_BYTEENABLE));
            default: n.cfg = s.cfg;
         endcase
      end

      if (s.sv_on && tick && (s.st == ST_ACK || s.st == ST_POWER)) begin
         n.sv = 16'(dec_ms({1'b0, s.sv}));
         sv_expire = (s.sv == 16'h0001);
      end

      case (s.st)
         ST_IDLE: begin
            n.pwr = 1'b0;
            n.armed = 1'b0;
            if (trig) begin
               n.st = ST_ACK;
               n.ivl = 16'h0000;
               n.sv = s.cfg.superv_ms;
               n.sv_on = (s.cfg.superv_ms != 16'h0000);
            end
         end
         ST_ACK: begin
            n.pwr = 1'b0;
            if (!p.fault) begin
               if (s.cfg.mode == MODE_ACK_ONLY) begin
                  n.st = ST_GUARD;
                  n.gap = 17'h00000;
               end else if (s.cnt == 8'h00) begin
                  n.st = ST_FAILED;
               end else begin
                  n.cnt = 8'(s.cnt - 8'h01);
                  n.st = ST_POWER;
               end
            end else if (tick) begin
               if (s.ivl == 16'h0000) begin
                  // retry every half wait time
                  // reload one short: the tick reaching zero is
                  // itself the acknowledge tick of the next interval
                  n.ivl = 16'(dec_ms({2'b00, s.cfg.wait_ms[15:1]}));
                  n.ack = p.cause_gone;
                  n.armed = 1'b1;
                  if (s.armed) begin
                     n.sv = s.cfg.superv_ms;
                  end
               end else begin
                  n.ivl = 16'(s.ivl - 16'h0001);
               end
            end
         end
         ST_GUARD: begin
            if (tick) begin
               n.gap = (s.gap == 17'h1ffff) ? s.gap : 17'(s.gap + 17'h00001);
            end
            // early fault: no acknowledge, no failure
            if (p.fault) begin
               n.st = (s.gap >= gap_need) ? ST_IDLE : ST_HOLD;
            end else if (s.gap >= gap_need) begin
               n.st = ST_IDLE;
            end
         end
         ST_HOLD: begin
            if (!p.fault) begin
               n.st = ST_IDLE;
            end
         end
         ST_POWER: begin
            // power up once supply is back
            n.pwr = p.line_ok;
            if (p.fault) begin
               n.st = ST_ACK;
               n.ivl = 16'h0000;
               n.armed = 1'b0;
            end else if (p.mag_done) begin
               n.st = ST_SETTLE;
               n.gap = 17'h00000;
            end
         end
         ST_SETTLE: begin
            n.pwr = 1'b1;
            if (tick) begin
               n.gap = 17'(s.gap + 17'h00001);
            end
            // further faults go back to acknowledge
            if (p.fault) begin
               n.st = ST_ACK;
               n.ivl = 16'h0000;
               n.armed = 1'b0;
            end else if (s.gap >= SETTLE_MS) begin
               n.cnt = s.cfg.attempts;
               n.sv_on = 1'b0;
               n.st = ST_IDLE;
            end
         end
         ST_FAILED: begin
            n.pwr = 1'b0;
            n.sv_on = 1'b0;
            if (clr || !mode_ok) begin
               n.st = ST_IDLE;
               n.cnt = s.cfg.attempts;
            end
         end
         default: n.st = ST_IDLE;
      endcase

      // expiry wins over any transition of this cycle except leaving an active mode
      // so power up never stands beside the failure flag
      if (sv_expire) begin
         n.st = ST_FAILED;
         n.pwr = 1'b0;
      end

      // mode 1 never flags a failed acknowledge, only supervision
      n.failed = (n.st == ST_FAILED);
      // leaving an active mode stops everything
      if (!mode_ok && s.st != ST_FAILED) begin
         n.st = ST_IDLE;
         n.pwr = 1'b0;
         n.ack = 1'b0;
         n.failed = 1'b0;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         s <= RESET_S;
      end else begin
         s <= n;
      end
   end

   assign AVS_READDATA = s.rdata;
   assign AVS_WAITREQUEST = s.wreq;
   assign FAULT_ACK = s.ack;
   assign POWER_UP = s.pwr;
   assign RESTART_FAILED_FAULT = s.failed;
   // flying restart enable driven out for the power section
   assign FLYING_RESTART_ENABLE = s.cfg.fly;
endmodule

// ===== testbench/ars_drive_model.sv
// Purpose: fault source and power section beside the sequencer
// Assumes: trip and clr are one-cycle requests from the bench
// Notes: magnetization only runs while power up is requested
`timescale 1ns/1ps
module ars_drive_model #(
   parameter int MAG_CYCLES = 30
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic trip,
   input wire logic clr,
   input wire logic persist,
   input wire logic fault_ack,
   input wire logic power_up,
   output logic fault_active,
   output logic mag_done
);
   int cnt;
   // a persistent fault survives every acknowledge
   always_ff @(posedge clk) begin
      if (!rst_n || clr) begin
         fault_active <= 1'b0;
      end else if (trip) begin
         fault_active <= 1'b1;
      end else if (fault_ack && !persist) begin
         fault_active <= 1'b0;
      end
      if (!power_up) begin
         cnt <= 0;
      end else if (cnt < MAG_CYCLES) begin
         cnt <= cnt + 1;
      end
   end
   assign mag_done = (cnt == MAG_CYCLES);
endmodule

// ===== testbench/ars_seq_asserts.sv
// Purpose: port checks of the restart sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: mode is tracked from bus writes, as no port shows it
`timescale 1ns/1ps
module ars_seq_asserts import ars_pkg::*; #(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic FAULT_ACK,
   input wire logic POWER_UP,
   input wire logic RESTART_FAILED_FAULT,
   input wire logic FLYING_RESTART_ENABLE
);
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   logic ctrl_wr;
   logic off;
   logic [2:0] mode_q;
   logic [15:0] since;
   assign ctrl_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_CTRL && AVS_BYTEENABLE[0];
   assign off = !(mode_q inside {MODE_ACK_ONLY, MODE_LINE, MODE_ANY});
   // saturating, so the first pulse after reset always passes
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         mode_q <= RST_MODE;
         since <= 16'hffff;
      end else begin
         if (ctrl_wr) begin
            mode_q <= AVS_WRITEDATA[2:0];
         end
         if (FAULT_ACK) begin
            since <= 16'h0000;
         end else if (since != 16'hffff) begin
            since <= since + 16'h0001;
         end
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   bus_answer_a: assert property ($rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST)
      else $error("bus answer not one cycle after request");
   bus_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than a cycle");
   unmapped_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > OFS_STATUS |-> AVS_READDATA == 32'h0)
      else $error("unmapped read not zero");
   ack_pulse_a: assert property (FAULT_ACK |=> !FAULT_ACK)
      else $error("acknowledge longer than one cycle");
   ack_spacing_a: assert property (FAULT_ACK |-> since >= TICK_LEN - 1)
      else $error("acknowledges closer than one tick");
   mode_off_a: assert property (off && $past(off) && $past(off, 2) |-> !FAULT_ACK && !POWER_UP)
      else $error("activity with restart disabled");
   ack_only_a: assert property (mode_q == MODE_ACK_ONLY && $past(mode_q, 2) == MODE_ACK_ONLY |-> !POWER_UP)
      else $error("power up in acknowledge-only mode");
   fail_dark_a: assert property (RESTART_FAILED_FAULT |-> !POWER_UP)
      else $error("power up while restart failed");
   fly_copy_a: assert property (ctrl_wr |-> ##2 FLYING_RESTART_ENABLE == $past(AVS_WRITEDATA[4], 2))
      else $error("flying restart enable not following control");
   fail_clear_a: assert property ($fell(RESTART_FAILED_FAULT) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
      else $error("restart failed cleared without control write");
   ack_seen_c: cover property (FAULT_ACK);
   power_seen_c: cover property ($rose(POWER_UP));
   fail_seen_c: cover property ($rose(RESTART_FAILED_FAULT));
endmodule

bind ars_sequencer ars_seq_asserts #(.TICK_LEN(TICK_LEN)) u_ars_seq_asserts (.CLK(CLK), .RST_N(RST_N),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .FAULT_ACK(FAULT_ACK), .POWER_UP(POWER_UP), .RESTART_FAILED_FAULT(RESTART_FAILED_FAULT),
   .FLYING_RESTART_ENABLE(FLYING_RESTART_ENABLE));

// ===== testbench/testbench.sv
// Purpose: self-checking bench of the restart sequencer
// Assumes: time base shortened to TLEN cycles per ms
// Notes: wait time set to 4 ms so acknowledges repeat every 2 ms
`timescale 1ns/1ps
module testbench import ars_pkg::*; ;
   localparam int TLEN = 10;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic [4:0] AVS_ADDRESS = 5'h00;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [3:0] AVS_BYTEENABLE = 4'hf;
   logic [31:0] AVS_READDATA, q;
   logic AVS_WAITREQUEST, FAULT_ACTIVE, FAULT_ACK, POWER_UP, RESTART_FAILED_FAULT, FLYING_RESTART_ENABLE, mag;
   logic trip = 1'b0, clr = 1'b0, persist = 1'b0, gone = 1'b1, line_ok = 1'b1;
   logic run = 1'b0, in0 = 1'b0;
   logic [3:0] trig = 4'h0;
   logic [2:0] outs;
   int failures = 0, check_count = 0, cyc = 0;
   assign outs = {RESTART_FAILED_FAULT, POWER_UP, FAULT_ACK};
   always #12.5 CLK = ~CLK;
   ars_sequencer #(.TICK_LEN(TLEN)) u_ars_sequencer (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .FAULT_ACTIVE(FAULT_ACTIVE),
      .FAULT_CAUSE_GONE(gone), .MOTOR_LINE_FAILURE_FAULT(trig[0]), .INFEED_LINE_FAULT(trig[3]),
      .INFEED_FAULT_INPUTS({trig[1], in0}), .SUPPLY24_FAIL(trig[2]), .LINE_OK(line_ok), .RUN_COMMAND(run),
      .MAGNETIZATION_DONE_FLAG(mag), .IS_INFEED(trig[3]), .FAULT_ACK(FAULT_ACK), .POWER_UP(POWER_UP),
      .RESTART_FAILED_FAULT(RESTART_FAILED_FAULT), .FLYING_RESTART_ENABLE(FLYING_RESTART_ENABLE));
   ars_drive_model u_ars_drive_model (.clk(CLK), .rst_n(RST_N), .trip(trip), .clr(clr), .persist(persist),
      .fault_ack(FAULT_ACK), .power_up(POWER_UP), .fault_active(FAULT_ACTIVE), .mag_done(mag));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] be, input logic [4:0] a, input logic [31:0] d);
      @(posedge CLK);
      AVS_WRITE <= w;
      AVS_READ <= !w;
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_BYTEENABLE <= be;
      // no cycle limit here: a stalled slave is caught by the bench timeout
      do begin
         @(posedge CLK);
      end while (AVS_WAITREQUEST !== 1'b0);
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, 4'hf, a, d);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, 4'hf, a, 32'h0);
      chk(q, e);
   endtask
   // level seen at any edge of the window, so one-cycle pulses count
   task automatic want(input int s, input int lim, input logic e);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < lim && hit !== 1'b1; i++) begin
         @(posedge CLK);
         hit = outs[s];
      end
      chk(hit, e);
   endtask
   task automatic kick(input logic c);
      @(posedge CLK);
      if (c) clr <= 1'b1;
      else trip <= 1'b1;
      @(posedge CLK);
      clr <= 1'b0;
      trip <= 1'b0;
   endtask
   task automatic finish_test;
      $display("checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs;
      rd(OFS_ATTEMPTS, 32'h3);
      rd(OFS_SUPERV, 32'h0);
      rd(OFS_WAIT, 32'h3e8);
      rd(OFS_STATUS, 32'h300);
      rd(5'h14, 32'h0);
      bus(1'b1, 4'h2, OFS_ATTEMPTS, 32'h705);
      rd(OFS_ATTEMPTS, 32'h3);
      wr(OFS_WAIT, 32'h4);
      $display("test regs done");
   endtask
   task automatic t_off;
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CTRL, i ? 32'h3 : 32'h0);
         kick(1'b0);
         want(0, 300, 1'b0);
         want(1, 10, 1'b0);
         kick(1'b1);
      end
      $display("test off done");
   endtask
   task automatic t_any;
      wr(OFS_ATTEMPTS, 32'h1);
      wr(OFS_CTRL, 32'h16);
      kick(1'b0);
      chk(FLYING_RESTART_ENABLE, 1'b1);
      want(0, 30, 1'b1);
      want(1, 30, 1'b1);
      rd(OFS_STATUS, 32'h2_0004);
      kick(1'b0);
      want(2, 100, 1'b1);
      wr(OFS_CTRL, 32'h116);
      repeat (3) @(posedge CLK);
      chk(RESTART_FAILED_FAULT, 1'b0);
      wr(OFS_ATTEMPTS, 32'h2);
      kick(1'b0);
      want(1, 60, 1'b1);
      repeat (100) @(posedge CLK);
      rd(OFS_STATUS, 32'h2_0105);
      repeat (10000) @(posedge CLK);
      rd(OFS_STATUS, 32'h200);
      in0 <= 1'b1;
      want(1, 30, 1'b1);
      in0 <= 1'b0;
      $display("test any-fault done");
   endtask
   task automatic t_ack;
      wr(OFS_CTRL, 32'h0);
      wr(OFS_CTRL, 32'h1);
      kick(1'b0);
      want(0, 30, 1'b1);
      want(1, 200, 1'b0);
      kick(1'b0);
      want(0, 200, 1'b0);
      want(2, 10, 1'b0);
      kick(1'b1);
      // next fault about 1002 ticks after the acknowledge: early only with run high
      for (int i = 0; i < 2; i++) begin
         run <= (i == 0);
         kick(1'b0);
         want(0, 30, 1'b1);
         repeat (10020) @(posedge CLK);
         kick(1'b0);
         want(0, 200, i == 1);
         kick(1'b1);
      end
      run <= 1'b0;
      wr(OFS_CTRL, 32'h0);
      $display("test ack-only done");
   endtask
   task automatic t_line;
      wr(OFS_CTRL, 32'h4);
      kick(1'b0);
      want(0, 100, 1'b0);
      kick(1'b1);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CTRL, 32'h4);
         trig <= 4'h1 << i;
         kick(1'b0);
         want(0, 100, 1'b1);
         trig <= 4'h0;
         wr(OFS_CTRL, 32'h0);
      end
      $display("test line done");
   endtask
   task automatic t_sup;
      int n;
      wr(OFS_ATTEMPTS, 32'h3);
      wr(OFS_SUPERV, 32'h4);
      wr(OFS_CTRL, 32'h6);
      persist <= 1'b1;
      kick(1'b0);
      want(0, 30, 1'b1);
      for (n = 1; n < 100; n++) begin
         @(posedge CLK);
         if (outs[0] === 1'b1) break;
      end
      chk(n, 2 * TLEN);
      want(2, 200, 1'b0);
      persist <= 1'b0;
      line_ok <= 1'b0;
      want(2, 200, 1'b1);
      line_ok <= 1'b1;
      wr(OFS_CTRL, 32'h0);
      // supervision shorter than the wait time in acknowledge-only mode
      wr(OFS_SUPERV, 32'h1);
      wr(OFS_CTRL, 32'h1);
      persist <= 1'b1;
      kick(1'b0);
      want(2, 50, 1'b1);
      persist <= 1'b0;
      kick(1'b1);
      wr(OFS_CTRL, 32'h0);
      $display("test supervision done");
   endtask
   // ----------------------------------------
   // main sequence and timeout
   // ----------------------------------------
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 50000) begin
         failures++;
         $display("unexpected at %0t: timeout", $time);
         finish_test();
      end
   end
   initial begin
      repeat (10) @(posedge CLK);
      RST_N <= 1'b1;
      t_regs();
      t_off();
      t_any();
      t_ack();
      t_line();
      t_sup();
      finish_test();
   end
endmodule
